// ### modbus_fn_pkg.sv
/*
  Constants and types shared by the Modbus/TCP server function engine.
  Assumes byte positions count from the first header byte of a frame.
*/
package modbus_fn_pkg;

  // Function codes served and the flag that marks an abnormal reply.
  localparam logic [7:0] FN_READ_INPUT = 8'h04;
  localparam logic [7:0] FN_WRITE_COIL = 8'h05;
  localparam logic [7:0] FN_WRITE_HOLD = 8'h06;
  localparam logic [7:0] FN_READ_EXC = 8'h07;
  localparam logic [7:0] FN_ERR_FLAG = 8'h80;

  // Exception codes.
  localparam logic [7:0] EXC_ILLEGAL_FUNCTION = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDRESS = 8'h02;
  localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;

  // Coil value bytes.
  localparam logic [7:0] COIL_ON = 8'hFF;
  localparam logic [7:0] COIL_OFF = 8'h00;
  localparam logic [7:0] COIL_PAD = 8'h00;

  // Byte positions within a frame; the body starts after a seven-byte header.
  localparam logic [3:0] POS_FC = 4'h7;
  localparam logic [3:0] POS_REF_HI = 4'h8;
  localparam logic [3:0] POS_REF_LO = 4'h9;
  localparam logic [3:0] POS_ARG_HI = 4'hA;
  localparam logic [3:0] POS_ARG_LO = 4'hB;
  localparam logic [3:0] POS_OVER = 4'hC;

  // Word count limits and the end (one past last address) of the input word area.
  localparam logic [15:0] WORDS_MIN = 16'h0001;
  localparam logic [15:0] WORDS_MAX = 16'h007D;
  localparam logic [16:0] INPUT_AREA_END = 17'h10000;

  // Reply lengths in bytes, counted from the function code byte.
  localparam logic [7:0] SHORT_LEN = 8'h02;
  localparam logic [7:0] ECHO_LEN = 8'h05;
  localparam logic [7:0] READ_HDR_LEN = 8'h02;

  typedef enum logic [4:0] {
    ST_RX = 5'h01,
    ST_EXEC = 5'h02,
    ST_FETCH = 5'h04,
    ST_LOAD = 5'h08,
    ST_TX = 5'h10
  } fsm_t;

endpackage

// ### fn_check.sv
/*
  Request validator: decides whether a decoded request is served or which
  exception code answers it. Purely combinational; fed from registered fields.
*/
module fn_check (
  input wire logic [7:0] fc,
  input wire logic [15:0] ref_no,
  input wire logic [15:0] arg,
  input wire logic full,
  output logic ok,
  output logic [7:0] exc_code
);

  logic [16:0] range_end;

  always_comb begin
    range_end = {1'b0, ref_no} + {1'b0, arg};
    ok = 1'b0;
    exc_code = modbus_fn_pkg::EXC_ILLEGAL_VALUE;
    unique case (fc)
      modbus_fn_pkg::FN_READ_INPUT: begin
        if (!full || arg < modbus_fn_pkg::WORDS_MIN || arg > modbus_fn_pkg::WORDS_MAX) begin
          exc_code = modbus_fn_pkg::EXC_ILLEGAL_VALUE;
        end else if (range_end > modbus_fn_pkg::INPUT_AREA_END) begin
          exc_code = modbus_fn_pkg::EXC_ILLEGAL_ADDRESS;
        end else begin
          ok = 1'b1;
        end
      end
      modbus_fn_pkg::FN_WRITE_COIL: begin
        ok = full && arg[7:0] == modbus_fn_pkg::COIL_PAD
          && (arg[15:8] == modbus_fn_pkg::COIL_ON || arg[15:8] == modbus_fn_pkg::COIL_OFF);
      end
      modbus_fn_pkg::FN_WRITE_HOLD: begin
        ok = full;
      end
      modbus_fn_pkg::FN_READ_EXC: begin
        ok = 1'b1;
      end
      default: begin
        exc_code = modbus_fn_pkg::EXC_ILLEGAL_FUNCTION;
      end
    endcase
  end

endmodule

// ### modbus_fn_server.sv
/*
  Modbus/TCP server function engine: takes request frames byte by byte,
  serves read input words, write single coil, write single holding word and
  read exception status, and streams the reply body from the function code on.
  Assumes the surrounding logic rebuilds the transport header (the engine skips the received one) and
  that the input word area answers a read in the same cycle it is strobed.
*/

module modbus_fn_server (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready,
  output logic input_rd,
  output logic [15:0] input_addr,
  input wire logic [15:0] input_rdata,
  output logic coil_we,
  output logic coil_on,
  output logic [15:0] wr_addr,
  output logic hold_we,
  output logic [15:0] hold_wdata,
  input wire logic [15:0] hold_first_word
);

  typedef struct packed {
    modbus_fn_pkg::fsm_t fsm;
    logic [3:0] pos;
    logic [7:0] fc;
    logic [15:0] ref_no;
    logic [15:0] arg;
    logic full;
    logic err;
    logic [7:0] b1;
    logic [7:0] len;
    logic [7:0] idx;
    logic [15:0] word;
    logic [15:0] rd_addr;
    logic rx_ready;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_last;
    logic input_rd;
    logic coil_we;
    logic coil_on;
    logic hold_we;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic chk_ok;
  logic [7:0] chk_exc;
  logic [7:0] next_idx;
  logic reading;

  fn_check u_check (
    .fc(s_q.fc),
    .ref_no(s_q.ref_no),
    .arg(s_q.arg),
    .full(s_q.full),
    .ok(chk_ok),
    .exc_code(chk_exc)
  );

  // Reply byte at a given index, for everything except the high byte of each fetched word.
  function automatic logic [7:0] pick(input state_t s, input logic [7:0] n);
    logic [7:0] b;
    b = s.b1;
    if (n == 8'h00) begin
      b = s.err ? (s.fc | modbus_fn_pkg::FN_ERR_FLAG) : s.fc;
    end else if (!s.err && (s.fc == modbus_fn_pkg::FN_WRITE_COIL
        || s.fc == modbus_fn_pkg::FN_WRITE_HOLD)) begin
      unique case (n)
        8'h01: b = s.ref_no[15:8];
        8'h02: b = s.ref_no[7:0];
        8'h03: b = s.arg[15:8];
        default: b = s.arg[7:0];
      endcase
    end else if (n != 8'h01) begin
      b = s.word[7:0];
    end
    return b;
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.input_rd = 1'b0;
    s_d.coil_we = 1'b0;
    s_d.hold_we = 1'b0;
    next_idx = s_q.idx + 8'h01;
    reading = !s_q.err && s_q.fc == modbus_fn_pkg::FN_READ_INPUT;
    unique case (s_q.fsm)
      modbus_fn_pkg::ST_RX: begin
        s_d.rx_ready = 1'b1;
        if (rx_valid && s_q.rx_ready) begin
          unique case (s_q.pos)
            modbus_fn_pkg::POS_FC: s_d.fc = rx_data;
            modbus_fn_pkg::POS_REF_HI: s_d.ref_no[15:8] = rx_data;
            modbus_fn_pkg::POS_REF_LO: s_d.ref_no[7:0] = rx_data;
            modbus_fn_pkg::POS_ARG_HI: s_d.arg[15:8] = rx_data;
            modbus_fn_pkg::POS_ARG_LO: begin
              s_d.arg[7:0] = rx_data;
              s_d.full = 1'b1;
            end
            default: begin
            end
          endcase
          if (s_q.pos != modbus_fn_pkg::POS_OVER) begin
            s_d.pos = s_q.pos + 4'h1;
          end
          if (rx_last) begin
            s_d.fsm = modbus_fn_pkg::ST_EXEC;
            s_d.rx_ready = 1'b0;
            s_d.pos = 4'h0;
          end
        end
      end
      modbus_fn_pkg::ST_EXEC: begin
        s_d.err = !chk_ok;
        s_d.idx = 8'h00;
        s_d.rd_addr = s_q.ref_no;
        s_d.tx_valid = 1'b1;
        s_d.tx_last = 1'b0;
        s_d.fsm = modbus_fn_pkg::ST_TX;
        s_d.len = modbus_fn_pkg::SHORT_LEN;
        s_d.b1 = chk_exc;
        if (!chk_ok) begin
          s_d.tx_data = s_q.fc | modbus_fn_pkg::FN_ERR_FLAG;
        end else begin
          s_d.tx_data = s_q.fc;
          unique case (s_q.fc)
            modbus_fn_pkg::FN_READ_INPUT: begin
              s_d.b1 = {s_q.arg[6:0], 1'b0};
              s_d.len = modbus_fn_pkg::READ_HDR_LEN + {s_q.arg[6:0], 1'b0};
            end
            modbus_fn_pkg::FN_WRITE_COIL: begin
              s_d.coil_we = 1'b1;
              s_d.coil_on = s_q.arg[15:8] == modbus_fn_pkg::COIL_ON;
              s_d.len = modbus_fn_pkg::ECHO_LEN;
            end
            modbus_fn_pkg::FN_WRITE_HOLD: begin
              s_d.hold_we = 1'b1;
              s_d.len = modbus_fn_pkg::ECHO_LEN;
            end
            default: begin
              s_d.b1 = hold_first_word[7:0];
            end
          endcase
        end
      end
      modbus_fn_pkg::ST_TX: begin
        if (tx_ready) begin
          if (s_q.tx_last) begin
            s_d.fsm = modbus_fn_pkg::ST_RX;
            s_d.tx_valid = 1'b0;
            s_d.tx_last = 1'b0;
            s_d.full = 1'b0;
            s_d.rx_ready = 1'b1;
          end else begin
            s_d.idx = next_idx;
            if (reading && next_idx[0] == 1'b0) begin
              s_d.fsm = modbus_fn_pkg::ST_FETCH;
              s_d.tx_valid = 1'b0;
            end else begin
              s_d.tx_data = pick(s_q, next_idx);
              s_d.tx_last = next_idx == s_q.len - 8'h01;
            end
          end
        end
      end
      modbus_fn_pkg::ST_FETCH: begin
        s_d.input_rd = 1'b1;
        s_d.fsm = modbus_fn_pkg::ST_LOAD;
      end
      modbus_fn_pkg::ST_LOAD: begin
        s_d.word = input_rdata;
        s_d.rd_addr = s_q.rd_addr + 16'h0001;
        s_d.tx_data = input_rdata[15:8];
        s_d.tx_valid = 1'b1;
        s_d.tx_last = 1'b0;
        s_d.fsm = modbus_fn_pkg::ST_TX;
      end
      default: begin
        s_d.fsm = modbus_fn_pkg::ST_RX;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '{fsm: modbus_fn_pkg::ST_RX, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign rx_ready = s_q.rx_ready;
  assign tx_valid = s_q.tx_valid;
  assign tx_data = s_q.tx_data;
  assign tx_last = s_q.tx_last;
  assign input_rd = s_q.input_rd;
  assign input_addr = s_q.rd_addr;
  assign coil_we = s_q.coil_we;
  assign coil_on = s_q.coil_on;
  assign wr_addr = s_q.ref_no;
  assign hold_we = s_q.hold_we;
  assign hold_wdata = s_q.arg;

endmodule

// ### input_area_model.sv
/* Model of the input word area beside the server.
   Assumes reads are strobed by input_rd and answered in the same cycle. */
module input_area_model (
  input wire logic input_rd,
  input wire logic [15:0] input_addr,
  output logic [15:0] input_rdata
);
  // Between reads the bus shows the inverse, so stale data never looks valid.
  assign input_rdata = input_rd ? (input_addr ^ 16'hC3A5) : ~(input_addr ^ 16'hC3A5);
endmodule

// ### modbus_fn_checker.sv
/* Port checker for the server function engine.
   Assumes it is bound to the server and sees only its ports. */
module modbus_fn_checker (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_ready,
  input wire logic input_rd,
  input wire logic [15:0] input_rdata,
  input wire logic coil_we,
  input wire logic hold_we
);
  logic [7:0] hi_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  always_ff @(posedge mclk) begin
    hi_q <= input_rdata[15:8];
  end
  sequence word_load;
    input_rd ##1 tx_valid;
  endsequence
  coil_pulse_a: assert property (coil_we |=> !coil_we) else $error("coil strobe long");
  hold_pulse_a: assert property (hold_we |=> !hold_we) else $error("hold strobe long");
  coil_echo_a: assert property (coil_we |-> tx_valid && tx_data == 8'h05)
    else $error("coil strobe without echo");
  hold_echo_a: assert property (hold_we |-> tx_valid && tx_data == 8'h06)
    else $error("hold strobe without echo");
  word_high_a: assert property (word_load |-> tx_data == hi_q) else $error("word order");
  read_pulse_a: assert property (input_rd |=> !input_rd) else $error("read strobe long");
  reply_hold_a: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data) && $stable(tx_last)) else $error("reply byte dropped");
  one_way_a: assert property (tx_valid |-> !rx_ready) else $error("rx open in reply");
endmodule

bind modbus_fn_server modbus_fn_checker i_modbus_fn_checker (.mclk(mclk), .nrst(nrst),
  .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
  .tx_ready(tx_ready), .input_rd(input_rd), .input_rdata(input_rdata),
  .coil_we(coil_we), .hold_we(hold_we));

// ### tb_modbus_fn_server.sv
/* Self-checking bench for the server function engine.
   Plays the client on both streams; the input word area is a model. */
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin err_total++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb_modbus_fn_server;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, nrst, rx_valid, rx_last, tx_ready, rx_ready, tx_valid, tx_last;
  logic input_rd, coil_we, coil_on, hold_we;
  logic [7:0] rx_data, tx_data;
  logic [15:0] input_addr, input_rdata, wr_addr, hold_wdata, hold_first_word;
  int err_total, n_checks, cyc, strobes;
  bit stall;
  logic [7:0] exp_q[$];
  modbus_fn_server i_modbus_fn_server (.mclk(mclk), .nrst(nrst), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .input_rd(input_rd),
    .input_addr(input_addr), .input_rdata(input_rdata), .coil_we(coil_we),
    .coil_on(coil_on), .wr_addr(wr_addr), .hold_we(hold_we), .hold_wdata(hold_wdata),
    .hold_first_word(hold_first_word));
  input_area_model i_input_area_model (.input_rd(input_rd), .input_addr(input_addr),
    .input_rdata(input_rdata));
  initial begin
    mclk = 0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Strobes are counted mid-cycle, away from the edge that launches them.
  always @(negedge mclk) begin
    cyc++;
    if (coil_we | hold_we) strobes++;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end
  // Sends header plus n body bytes, then collects the reply and compares it with exp_q.
  task automatic xfer(input logic [39:0] body, input int n);
    logic [7:0] got[$];
    int w;
    for (int i = 0; i < 7 + n; i++) begin
      @(negedge mclk);
      rx_valid = 1;
      rx_data = i < 7 ? 8'hA5 : body[39 - 8 * (i - 7) -: 8];
      rx_last = i == 6 + n;
      w = 0;
      while (rx_ready !== 1'b1 && w < 50) begin
        @(negedge mclk);
        w++;
      end
      @(posedge mclk);
    end
    @(negedge mclk);
    rx_valid = 0;
    rx_last = 0;
    w = 0;
    forever begin
      tx_ready = stall ? ~tx_ready : 1'b1;
      if (tx_valid === 1'b1 && tx_ready) begin
        got.push_back(tx_data);
        if (tx_last === 1'b1) break;
      end
      if (++w > 1000) break;
      @(negedge mclk);
    end
    @(negedge mclk);
    tx_ready = 1;
    `CHK("length", exp_q.size(), got.size())
    foreach (exp_q[i]) `CHK("reply byte", exp_q[i], i < got.size() ? got[i] : 8'hXX)
  endtask
  task automatic t_read();
    logic [15:0] v;
    exp_q = '{8'h04, 8'h04, 8'hC3, 8'hB5, 8'hC3, 8'hB4};
    stall = 1;
    xfer(40'h04_0010_0002, 5);
    stall = 0;
    exp_q = '{8'h04, 8'hFA};
    for (int a = 'hFF83; a <= 'hFFFF; a++) begin
      v = a[15:0] ^ 16'hC3A5;
      exp_q.push_back(v[15:8]);
      exp_q.push_back(v[7:0]);
    end
    xfer(40'h04_FF83_007D, 5);
  endtask
  task automatic t_read_bad();
    exp_q = '{8'h84, 8'h03};
    xfer(40'h04_0000_0000, 5);
    xfer(40'h04_0000_007E, 5);
    exp_q = '{8'h84, 8'h02};
    xfer(40'h04_FF84_007D, 5);
  endtask
  task automatic t_coil();
    int s;
    s = strobes;
    exp_q = '{8'h05, 8'h00, 8'h03, 8'hFF, 8'h00};
    xfer(40'h05_0003_FF00, 5);
    `CHK("coil_on", 1'b1, coil_on)
    `CHK("wr_addr", 16'h0003, wr_addr)
    exp_q[3] = 8'h00;
    xfer(40'h05_0003_0000, 5);
    `CHK("coil_on", 1'b0, coil_on)
    exp_q = '{8'h85, 8'h03};
    xfer(40'h05_0003_1200, 5);
    `CHK("strobes", s + 2, strobes)
  endtask
  task automatic t_hold();
    exp_q = '{8'h06, 8'h12, 8'h34, 8'hAB, 8'hCD};
    xfer(40'h06_1234_ABCD, 5);
    `CHK("hold_wdata", 16'hABCD, hold_wdata)
    `CHK("wr_addr", 16'h1234, wr_addr)
    exp_q = '{8'h86, 8'h03};
    xfer(40'h06_1234_AB00, 4);
  endtask
  task automatic t_status();
    hold_first_word = 16'hA55A;
    exp_q = '{8'h07, 8'h5A};
    xfer(40'h07_0000_0000, 1);
  endtask
  task automatic t_unsup();
    logic [7:0] fcs[3] = '{8'h03, 8'h08, 8'h2B};
    foreach (fcs[k]) begin
      exp_q = '{fcs[k] | 8'h80, 8'h01};
      xfer({fcs[k], 32'h0}, 5);
    end
  endtask
  initial begin
    {nrst, rx_valid, rx_last, tx_ready, stall} = '0;
    rx_data = '0;
    hold_first_word = '0;
    repeat (8) @(negedge mclk);
    nrst = 1;
    t_read();
    t_read_bad();
    t_coil();
    t_hold();
    t_status();
    t_unsup();
    report_and_stop();
  end
endmodule
